// ---- isk_pkg.sv ----
// shared constants for the increment-skip / or-immediate executor
package isk_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int DEPTH = 128;
  // opcode fields
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_OR_IMM = 6'h38;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  // phases of one instruction cycle, gray coded
  typedef enum logic [1:0] {
    ISK_DECODE = 2'b00,
    ISK_READ = 2'b01,
    ISK_PROCESS = 2'b11,
    ISK_WRITE = 2'b10
  } isk_phase_type;
endpackage

// ---- isk_alu.sv ----
// result unit: increment and or-immediate
`timescale 1ns/1ps
module isk_alu
  import isk_pkg::*;
(
  input wire logic [DATA_W-1:0] operand,
  input wire logic [DATA_W-1:0] accum,
  input wire logic [DATA_W-1:0] immediate,
  input wire logic selOr,
  output logic [DATA_W-1:0] result,
  output logic resultZero
);
  // pick the operation, result wraps at 8 bits
  always_comb
  begin
    if (selOr)
      result = accum | immediate; // RQ3
    else
      result = operand + ONE; // RQ1
    resultZero = (result == ZERO);
  end
endmodule

// ---- isk_exec.sv ----
// four-phase executor for increment-skip and or-immediate instructions
// ==========================================
// Behaviour
// RQ1 - increment-skip reads the addressed data register and adds one to form the result.
// RQ2 - the destination bit sends the result to the accumulator when 0 and back to the register when 1.
// RQ3 - or-immediate forms the bitwise or of the accumulator and the 8-bit immediate.
// RQ4 - or-immediate replaces the accumulator contents within its single instruction cycle.
// RQ5 - a zero increment result turns the next fetched instruction into a no-operation cycle, flags untouched.
`timescale 1ns/1ps
module isk_exec
  import isk_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [INSTR_W-1:0] instr,
  output logic instrTake,
  output logic [ADDR_W-1:0] dbgAddr,
  output logic [DATA_W-1:0] dbgData,
  output logic [DATA_W-1:0] accum,
  output logic skipping,
  output logic zeroFlag,
  output logic cycleDone
);
  // ==========================================
  // state
  isk_phase_type phase;
  logic [INSTR_W-1:0] held;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic resultZero;
  logic [DATA_W-1:0] mem [DEPTH];
  logic isInc;
  logic isOr;
  logic dest;

  // decoded fields of the held instruction
  assign isInc = (held[OPC_HI:OPC_LO] == OPC_INC_SKIP) && !skipping;
  assign isOr = (held[OPC_HI:OPC_LO] == OPC_OR_IMM) && !skipping;
  assign dest = held[DEST_BIT];
  assign instrTake = (phase == ISK_DECODE);
  assign cycleDone = (phase == ISK_WRITE);
  assign dbgAddr = held[ADDR_W-1:0];

  // ==========================================
  // phase sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
      phase <= ISK_DECODE;
    else
    begin
      case (phase)
        ISK_DECODE: phase <= ISK_READ;
        ISK_READ: phase <= ISK_PROCESS;
        ISK_PROCESS: phase <= ISK_WRITE;
        ISK_WRITE: phase <= ISK_DECODE;
        default: phase <= ISK_DECODE;
      endcase
    end
  end

  // latch instruction at decode
  always_ff @(posedge clk)
  begin
    if (rst)
      held <= '0;
    else if (phase == ISK_DECODE)
      held <= instr;
  end

  // operand read
  always_ff @(posedge clk)
  begin
    if (rst)
      operand <= ZERO;
    else if (phase == ISK_READ)
      operand <= mem[held[ADDR_W-1:0]]; // RQ1
  end

  isk_alu u_alu (
    .operand(operand),
    .accum(accum),
    .immediate(held[DATA_W-1:0]),
    .selOr(isOr),
    .result(result),
    .resultZero(resultZero)
  );

  // latch result at process
  always_ff @(posedge clk)
  begin
    if (rst)
      dbgData <= ZERO;
    else if (phase == ISK_PROCESS)
      dbgData <= result;
  end

  // accumulator write at end of cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      accum <= ACC_RESET;
    else if (phase == ISK_WRITE)
    begin
      if (isOr)
        accum <= dbgData; // RQ4
      else if (isInc && !dest)
        accum <= dbgData; // RQ2
    end
  end

  // data register write-back
  always_ff @(posedge clk)
  begin
    if (phase == ISK_WRITE && isInc && dest)
      mem[held[ADDR_W-1:0]] <= dbgData; // RQ2
  end

  // skip marker: next cycle executes as no-op
  always_ff @(posedge clk)
  begin
    if (rst)
      skipping <= 1'b0;
    else if (phase == ISK_WRITE)
      skipping <= isInc && (dbgData == ZERO); // RQ5
  end

  // zero flag: only or-immediate touches it, increment-skip leaves it
  always_ff @(posedge clk)
  begin
    if (rst)
      zeroFlag <= 1'b0;
    else if (phase == ISK_WRITE && isOr)
      zeroFlag <= (dbgData == ZERO); // RQ5
  end
endmodule

// ---- isk_exec_properties.sv ----
// port assertions for the executor
`timescale 1ns/1ps
module isk_exec_props import isk_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic instrTake,
  input wire logic [DATA_W-1:0] accum,
  input wire logic skipping,
  input wire logic zeroFlag,
  input wire logic cycleDone);
  // ====
  // takes that really execute
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic orGo = instrTake && !skipping && instr[OPC_HI:OPC_LO] == OPC_OR_IMM;
  wire logic incGo = instrTake && !skipping && instr[OPC_HI:OPC_LO] == OPC_INC_SKIP;
  or_result_a:
    assert property (orGo |-> ##3 cycleDone ##1 accum == ($past(accum, 4) | $past(instr[7:0], 4)))
    else $error("or");
  acc_hold_a:
    assert property (!cycleDone |=> $stable(accum)) else $error("hold");
  inc_dest_a:
    assert property (incGo && instr[DEST_BIT] |-> ##4 accum == $past(accum, 4)) else $error("dest");
  flag_keep_a:
    assert property (incGo |-> ##4 zeroFlag == $past(zeroFlag, 4)) else $error("flag");
  skip_start_a:
    assert property ($changed(skipping) |-> $past(cycleDone)) else $error("skip");
endmodule
bind isk_exec isk_exec_props u_isk_exec_props (.clk(clk), .rst(rst), .instr(instr), .instrTake(instrTake),
  .accum(accum), .skipping(skipping), .zeroFlag(zeroFlag), .cycleDone(cycleDone));

// ---- tb_isk_exec.sv ----
// self-checking bench for the executor
`timescale 1ns/1ps
module tb_isk_exec import isk_pkg::*;
();
  logic clk = 0;
  logic rst = 1;
  logic [INSTR_W-1:0] instr = 14'h0000;
  logic instrTake, skipping, zeroFlag, cycleDone;
  logic [DATA_W-1:0] accum, acc, k, dbgData;
  logic [31:0] s = 32'h0001_71a9;
  int nFail = 0, nCompared = 0;
  // ====
  // clock and device
  initial forever #2.5 clk = ~clk;
  isk_exec u_isk_exec (.clk(clk), .rst(rst), .instr(instr), .instrTake(instrTake), .dbgAddr(), .dbgData(dbgData),
    .accum(accum), .skipping(skipping), .zeroFlag(zeroFlag), .cycleDone(cycleDone));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [9:0] a, input logic [9:0] e);
    nCompared++;
    nFail += int'(a !== e);
    if (a !== e)
      $display("CHECK FAILED %0t %h %h", $time, a, e);
  endtask
  task automatic endSim();
    $display("%0d compared %0d failed", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // or-immediates back to back, reset every eight, then two increments and a skipped or-immediate
  initial
  begin
    for (int n = 0; n < 40; n++)
    begin
      s = lfsr(s);
      k = n % 8 == 0 ? 8'h00 : n % 8 == 1 ? 8'hff : s[7:0];
      acc = (n % 8 == 0 ? 8'h00 : acc) | k;
      rst = n % 8 == 0;
      repeat (n == 0 ? 20 : n % 8 == 0) @(negedge clk);
      rst = 0;
      instr = {OPC_OR_IMM, k};
      repeat (4) @(negedge clk);
      chk({instrTake, zeroFlag, accum}, {1'b1, acc == ZERO, acc});
    end
    // preset one data register so the increment wraps to zero on the second pass
    u_isk_exec.mem[5] = 8'hfe;
    instr = {OPC_INC_SKIP, 1'b1, 7'h05};
    repeat (4) @(negedge clk);
    chk({instrTake, zeroFlag, accum}, {1'b1, acc == ZERO, acc});
    chk(dbgData, 8'hff);
    chk(skipping, 1'b0);
    instr = {OPC_INC_SKIP, 1'b0, 7'h05};
    repeat (4) @(negedge clk);
    chk({skipping, zeroFlag, accum}, {1'b1, acc == ZERO, 8'h00});
    // the instruction after the skip must do nothing
    instr = {OPC_OR_IMM, 8'h5a};
    repeat (4) @(negedge clk);
    chk({skipping, zeroFlag, accum}, {1'b0, acc == ZERO, 8'h00});
    endSim();
  end
endmodule
